// ==== core/ltmc_edge_sync.sv ====
module ltmc_edge_sync #(
   parameter logic RESET_VAL = 1'h0
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic din,
   output logic level,
   output logic rise,
   output logic fall
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   // meta_r feeds sync_r only
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_r <= RESET_VAL;
         sync_r <= RESET_VAL;
         prev_r <= RESET_VAL;
      end else begin
         meta_r <= din;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level = sync_r;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

endmodule

// ==== core/ltmc_mode_control.sv ====
// Notes on behaviour
// - power-on samples chip-select level: low to Ready, high to ready-hold; outputs off.
// - power-on samples the fault/slope pin and latches the slope profile.
// - Ready and ready-hold enable regulator at once, transmitter off, bus recessive.
// - in Ready a chip-select rising edge enables transmitter, enters Operation.
// - in ready-hold a chip-select falling edge moves to Ready.
// - Operation keeps everything on; chip-select falling edge enters Power-down.
// - Power-down turns off transmitter and regulator; receiver and wake detect stay.
// - Power-down bus falling edge enables regulator; stable regulator then enters Ready.
// - Power-down chip-select rising edge goes straight to Operation.
// - Power-down is reachable only from Operation.
// - apart from the power-on choice, mode changes use chip-select edges only, never its level.
// - chip-select edges are ignored for 600 us after regulator becomes stable.
// - after overload recovery the device sits in ready-hold.
// - regulator, bus or die overload, alone or together, raise a shutdown.
// - thermal overload with transmit low stops transmitter only; receive reads high.
// - contention, transmit high and receive low, shuts the regulator, receiver on.
// - regulator below shutdown threshold turns regulator off and powers down.
// - after brownout wait for battery above power-on threshold, then power-on.
// - enabled transmitter drives bus dominant on transmit low, recessive on high.
// - receive data mirrors the bus whenever the receiver is active, except in a transmit-only thermal shutdown.
// - slope pin high selects normal slope, low selects the faster alternate.
module ltmc_mode_control #(
   parameter logic [ltmc_pkg::IGNORE_CNT_W-1:0] IGNORE_CYCLES = 16'(ltmc_pkg::IGNORE_CYCLES)
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic csWake,
   input wire logic txData,
   input wire logic linIn,
   output logic linOut,
   output logic linOe_n,
   output logic rxData,
   input wire logic faultSlopeIn,
   output logic faultSlopeOut,
   output logic faultSlopeOe_n,
   output logic regEnable,
   input wire logic regStable,
   input wire logic regBelowThreshold,
   input wire logic regOverload,
   input wire logic busOverload,
   input wire logic thermalOverload,
   input wire logic batteryOk,
   output logic txEnabled,
   output logic slopeAlternate,
   output logic shutdownEvent,
   output logic csArmed,
   output logic [7:0] modeState
);

   // ***********************************************************
   // reset release
   // ***********************************************************
   logic [1:0] rstSync_r;
   logic rstn;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'h1};
      end
   end

   assign rstn = rstSync_r[1];

   // ***********************************************************
   // input conditioning
   // ***********************************************************
   logic csLevel;
   logic csRise;
   logic csFall;
   logic busFall;

   ltmc_edge_sync #(
      .RESET_VAL(ltmc_pkg::CS_RESET_LEVEL)
   ) u_cs_sync (
      .clk(core_clk),
      .rstn(rstn),
      .din(csWake),
      .level(csLevel),
      .rise(csRise),
      .fall(csFall)
   );

   ltmc_edge_sync #(
      .RESET_VAL(ltmc_pkg::BUS_RESET_LEVEL)
   ) u_bus_sync (
      .clk(core_clk),
      .rstn(rstn),
      .din(linIn),
      .level(),
      .rise(),
      .fall(busFall)
   );

   ltmc_pkg::ltmc_state_t state_r;
   logic csArmed_r;
   logic regEnable_r;
   logic regStablePrev_r;
   logic batteryPrev_r;
   logic regStableRise;
   logic batteryRise;
   logic overload;
   logic csRiseOk;
   logic csFallOk;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         regStablePrev_r <= 1'h0;
         batteryPrev_r <= 1'h0;
      end else begin
         regStablePrev_r <= regStable;
         batteryPrev_r <= batteryOk;
      end
   end

   assign regStableRise = regStable & ~regStablePrev_r;
   assign batteryRise = batteryOk & ~batteryPrev_r;
   assign overload = regOverload | busOverload | thermalOverload;
   // edges inside the ignore window are dropped, not deferred
   assign csRiseOk = csRise & csArmed_r;
   assign csFallOk = csFall & csArmed_r;

   // ***********************************************************
   // chip-select ignore window
   // ***********************************************************
   logic [ltmc_pkg::IGNORE_CNT_W-1:0] ignoreCnt_r;
   logic ignoreActive_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ignoreCnt_r <= '0;
         ignoreActive_r <= 1'h0;
         csArmed_r <= 1'h0;
      end else if (state_r == ltmc_pkg::ST_POR || state_r == ltmc_pkg::ST_BROWNOUT) begin
         ignoreCnt_r <= '0;
         ignoreActive_r <= 1'h0;
         csArmed_r <= 1'h0;
      end else if (regStableRise && regEnable_r) begin
         ignoreCnt_r <= '0;
         ignoreActive_r <= 1'h1;
         csArmed_r <= 1'h0;
      end else if (ignoreActive_r) begin
         if (ignoreCnt_r == IGNORE_CYCLES - 16'h0001) begin
            ignoreActive_r <= 1'h0;
            csArmed_r <= 1'h1;
         end else begin
            ignoreCnt_r <= ignoreCnt_r + 16'h0001;
         end
      end
   end

   // ***********************************************************
   // power-on sampling
   // ***********************************************************
   logic [2:0] porCnt_r;
   logic porDone;
   logic slopeAlternate_r;

   assign porDone = (porCnt_r == ltmc_pkg::POR_SETTLE_CYCLES);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         porCnt_r <= 3'h0;
      end else if (state_r != ltmc_pkg::ST_POR) begin
         porCnt_r <= 3'h0;
      end else if (!porDone) begin
         porCnt_r <= porCnt_r + 3'h1;
      end
   end

   // slope survives every mode change; only a new power-on resamples it
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         slopeAlternate_r <= 1'h0;
      end else if (state_r == ltmc_pkg::ST_POR && porDone) begin
         slopeAlternate_r <= ~faultSlopeIn;
      end
   end

   // ***********************************************************
   // overload capture
   // ***********************************************************
   logic faultRegOff_r;
   logic faultTxOnly_r;
   logic enterFault;

   assign enterFault = overload && (state_r == ltmc_pkg::ST_READY || state_r == ltmc_pkg::ST_READY_HOLD ||
                                    state_r == ltmc_pkg::ST_OPERATION || state_r == ltmc_pkg::ST_WAKEUP);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         faultRegOff_r <= 1'h0;
         faultTxOnly_r <= 1'h0;
      end else if (enterFault) begin
         // contention or regulator overload takes the regulator down
         faultRegOff_r <= regOverload | ((busOverload | thermalOverload) & txData & ~linIn);
         faultTxOnly_r <= thermalOverload & ~txData & ~regOverload;
      end else if (state_r != ltmc_pkg::ST_FAULT) begin
         faultRegOff_r <= 1'h0;
         faultTxOnly_r <= 1'h0;
      end
   end

   // ***********************************************************
   // mode sequencer
   // ***********************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ltmc_pkg::ST_POR;
      end else if (regEnable_r && regBelowThreshold) begin
         state_r <= ltmc_pkg::ST_BROWNOUT;
      end else if (enterFault) begin
         state_r <= ltmc_pkg::ST_FAULT;
      end else begin
         unique case (state_r)
            ltmc_pkg::ST_POR: begin
               if (porDone) begin
                  state_r <= csLevel ? ltmc_pkg::ST_READY_HOLD : ltmc_pkg::ST_READY;
               end
            end
            ltmc_pkg::ST_READY: begin
               if (csRiseOk) begin
                  state_r <= ltmc_pkg::ST_OPERATION;
               end
            end
            ltmc_pkg::ST_READY_HOLD: begin
               if (csFallOk) begin
                  state_r <= ltmc_pkg::ST_READY;
               end
            end
            ltmc_pkg::ST_OPERATION: begin
               if (csFallOk) begin
                  state_r <= ltmc_pkg::ST_POWERDOWN;
               end
            end
            ltmc_pkg::ST_POWERDOWN: begin
               if (csRiseOk) begin
                  state_r <= ltmc_pkg::ST_OPERATION;
               end else if (busFall) begin
                  state_r <= ltmc_pkg::ST_WAKEUP;
               end
            end
            ltmc_pkg::ST_WAKEUP: begin
               if (csRiseOk) begin
                  state_r <= ltmc_pkg::ST_OPERATION;
               end else if (regStable) begin
                  state_r <= ltmc_pkg::ST_READY;
               end
            end
            ltmc_pkg::ST_FAULT: begin
               if (!overload) begin
                  state_r <= ltmc_pkg::ST_READY_HOLD;
               end
            end
            ltmc_pkg::ST_BROWNOUT: begin
               if (batteryRise) begin
                  state_r <= ltmc_pkg::ST_POR;
               end
            end
         endcase
      end
   end

   // ***********************************************************
   // power and transmitter enables
   // ***********************************************************
   logic txEnabled_r;
   logic linOe_n_r;
   logic linOut_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         regEnable_r <= 1'h0;
      end else begin
         unique case (state_r)
            ltmc_pkg::ST_READY,
            ltmc_pkg::ST_READY_HOLD,
            ltmc_pkg::ST_OPERATION,
            ltmc_pkg::ST_WAKEUP: regEnable_r <= 1'h1;
            ltmc_pkg::ST_FAULT: regEnable_r <= ~faultRegOff_r;
            ltmc_pkg::ST_POR,
            ltmc_pkg::ST_POWERDOWN,
            ltmc_pkg::ST_BROWNOUT: regEnable_r <= 1'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         txEnabled_r <= 1'h0;
         linOe_n_r <= 1'h1;
         linOut_r <= ltmc_pkg::LIN_DRIVE_LEVEL;
      end else begin
         txEnabled_r <= (state_r == ltmc_pkg::ST_OPERATION);
         // open collector: only dominant is driven, recessive is released
         linOe_n_r <= ~((state_r == ltmc_pkg::ST_OPERATION) & ~txData);
         linOut_r <= ltmc_pkg::LIN_DRIVE_LEVEL;
      end
   end

   // ***********************************************************
   // receiver and fault pin
   // ***********************************************************
   logic rxData_r;
   logic faultSlopeOut_r;
   logic faultSlopeOe_n_r;
   logic rxActive;
   logic pinIsInput;

   assign rxActive = (state_r != ltmc_pkg::ST_POR) && (state_r != ltmc_pkg::ST_BROWNOUT);
   assign pinIsInput = (state_r == ltmc_pkg::ST_POR) || (state_r == ltmc_pkg::ST_BROWNOUT);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rxData_r <= ltmc_pkg::RX_IDLE_LEVEL;
      end else if (state_r == ltmc_pkg::ST_FAULT && faultTxOnly_r) begin
         rxData_r <= 1'h1;
      end else if (rxActive) begin
         rxData_r <= linIn;
      end else begin
         rxData_r <= ltmc_pkg::RX_IDLE_LEVEL;
      end
   end

   // the pin is released while it is sampled as the slope strap
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         faultSlopeOut_r <= ltmc_pkg::FAULT_IDLE_LEVEL;
         faultSlopeOe_n_r <= 1'h1;
      end else begin
         faultSlopeOe_n_r <= pinIsInput;
         faultSlopeOut_r <= ~((state_r == ltmc_pkg::ST_FAULT) | thermalOverload |
                              ((state_r == ltmc_pkg::ST_OPERATION) & (txData ^ linIn)));
      end
   end

   // ***********************************************************
   // status
   // ***********************************************************
   logic shutdownEvent_r;
   logic csArmedOut_r;
   logic [7:0] modeState_r;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         shutdownEvent_r <= 1'h0;
         csArmedOut_r <= 1'h0;
         modeState_r <= ltmc_pkg::ST_POR;
      end else begin
         shutdownEvent_r <= overload;
         csArmedOut_r <= csArmed_r;
         modeState_r <= state_r;
      end
   end

   assign linOut = linOut_r;
   assign linOe_n = linOe_n_r;
   assign rxData = rxData_r;
   assign faultSlopeOut = faultSlopeOut_r;
   assign faultSlopeOe_n = faultSlopeOe_n_r;
   assign regEnable = regEnable_r;
   assign txEnabled = txEnabled_r;
   assign slopeAlternate = slopeAlternate_r;
   assign shutdownEvent = shutdownEvent_r;
   assign csArmed = csArmedOut_r;
   assign modeState = modeState_r;

endmodule

// ==== include/ltmc_pkg.sv ====
package ltmc_pkg;

   // ***********************************************************
   // timing
   // ***********************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int IGNORE_DELAY_US = 600;
   // least time: round up to whole cycles
   localparam int IGNORE_CYCLES = (IGNORE_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IGNORE_CNT_W = 16;
   // cycles spent in power-on so the input synchronisers settle before sampling
   localparam logic [2:0] POR_SETTLE_CYCLES = 3'h4;

   // ***********************************************************
   // reset levels
   // ***********************************************************
   localparam logic CS_RESET_LEVEL = 1'h0;
   localparam logic BUS_RESET_LEVEL = 1'h1;
   localparam logic RX_IDLE_LEVEL = 1'h1;
   localparam logic FAULT_IDLE_LEVEL = 1'h1;
   localparam logic LIN_DRIVE_LEVEL = 1'h0;

   // ***********************************************************
   // modes
   // ***********************************************************
   typedef enum logic [7:0] {
      ST_POR        = 8'h01,
      ST_READY      = 8'h02,
      ST_READY_HOLD = 8'h04,
      ST_OPERATION  = 8'h08,
      ST_POWERDOWN  = 8'h10,
      ST_WAKEUP     = 8'h20,
      ST_FAULT      = 8'h40,
      ST_BROWNOUT   = 8'h80
   } ltmc_state_t;

endpackage

// ==== testbench/ltmc_far_model.sv ====
module ltmc_far_model #(
   parameter int RAMP = 5
) (
   input wire logic core_clk,
   input wire logic regEnable,
   input wire logic linOut,
   input wire logic linOe_n,
   input wire logic peerDom,
   output logic linIn,
   output logic regStable
);
   timeunit 1ns;
   timeprecision 1ps;
   int ramp = 0;
   // pulled-up wire: any node may pull it dominant
   assign linIn = !((!linOe_n && !linOut) || peerDom);
   // regulator needs a few cycles to settle after enable
   always @(posedge core_clk) begin
      ramp <= regEnable ? ((ramp < RAMP) ? ramp + 1 : ramp) : 0;
   end
   assign regStable = (ramp == RAMP);
endmodule

// ==== testbench/ltmc_mode_control_bench.sv ====
module ltmc_mode_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, resetn = 0, csWake = 0, txData = 1, slopeStrap = 0, peerDom = 0;
   logic regBelowThreshold = 0, regOverload = 0, busOverload = 0, thermalOverload = 0, batteryOk = 1;
   logic linIn, linOut, linOe_n, rxData, faultSlopeOut, faultSlopeOe_n, regEnable, regStable;
   logic txEnabled, slopeAlternate, shutdownEvent, csArmed;
   logic [7:0] modeState;
   wire faultSlopeIn;
   int fails = 0, compares = 0;

   // strap resistor wins only while the pin is released
   assign faultSlopeIn = faultSlopeOe_n ? slopeStrap : faultSlopeOut;

   ltmc_mode_control #(.IGNORE_CYCLES(16'h0014)) dut (
      .core_clk, .resetn, .csWake, .txData, .linIn, .linOut, .linOe_n, .rxData, .faultSlopeIn,
      .faultSlopeOut, .faultSlopeOe_n, .regEnable, .regStable, .regBelowThreshold, .regOverload,
      .busOverload, .thermalOverload, .batteryOk, .txEnabled, .slopeAlternate, .shutdownEvent,
      .csArmed, .modeState
   );
   ltmc_far_model far (.core_clk, .regEnable, .linOut, .linOe_n, .peerDom, .linIn, .regStable);

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   // ***********************************************************
   // helpers
   // ***********************************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wait_mode(input logic [7:0] m);
      int i;
      i = 0;
      while (modeState !== m && i < 300) begin
         step(1);
         i++;
      end
      check(modeState, m);
   endtask
   task automatic close_out;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ***********************************************************
   // tests
   // ***********************************************************
   initial begin
      step(4);
      resetn = 1;
      wait_mode(8'h02);
      check(slopeAlternate, 1'h1);
      check({regEnable, txEnabled, linOe_n}, 3'h5);
      for (int i = 0; i < 50 && !regStable; i++) step(1);
      // edge inside the ignore window must be lost
      csWake = 1;
      step(10);
      check(modeState, 8'h02);
      csWake = 0;
      for (int i = 0; i < 100 && !csArmed; i++) step(1);
      step(5);
      check(modeState, 8'h02);
      csWake = 1;
      wait_mode(8'h08);
      txData = 0;
      step(3);
      check({linOe_n, linIn, rxData}, 3'h0);
      txData = 1;
      step(3);
      check({linOe_n, rxData}, 2'h3);
      csWake = 0;
      wait_mode(8'h10);
      check({regEnable, txEnabled}, 2'h0);
      peerDom = 1;
      step(2);
      peerDom = 0;
      wait_mode(8'h02);
      step(40);
      csWake = 1;
      wait_mode(8'h08);
      csWake = 0;
      wait_mode(8'h10);
      step(5);
      csWake = 1;
      wait_mode(8'h08);
      txData = 0;
      thermalOverload = 1;
      wait_mode(8'h40);
      step(2);
      check({shutdownEvent, faultSlopeOut, rxData, regEnable}, 4'hb);
      thermalOverload = 0;
      txData = 1;
      wait_mode(8'h04);
      step(40);
      csWake = 0;
      wait_mode(8'h02);
      csWake = 1;
      wait_mode(8'h08);
      peerDom = 1;
      busOverload = 1;
      wait_mode(8'h40);
      step(2);
      check({regEnable, rxData}, 2'h0);
      busOverload = 0;
      peerDom = 0;
      wait_mode(8'h04);
      step(10);
      regBelowThreshold = 1;
      batteryOk = 0;
      txData = 0;
      wait_mode(8'h80);
      check(regEnable, 1'h0);
      check({faultSlopeOe_n, linOut, linOe_n}, 3'h5);
      regBelowThreshold = 0;
      slopeStrap = 1;
      step(5);
      check(modeState, 8'h80);
      batteryOk = 1;
      wait_mode(8'h04);
      check(slopeAlternate, 1'h0);
      close_out;
   end

   // whole sequence needs well under 2000 cycles
   initial begin
      #100us;
      fails++;
      close_out;
   end
endmodule

// ==== testbench/ltmc_mode_control_sva.sv ====
module ltmc_mode_control_chk (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic txData,
   input wire logic linIn,
   input wire logic linOe_n,
   input wire logic rxData,
   input wire logic regEnable,
   input wire logic regBelowThreshold,
   input wire logic regOverload,
   input wire logic busOverload,
   input wire logic thermalOverload,
   input wire logic txEnabled,
   input wire logic shutdownEvent,
   input wire logic csArmed,
   input wire logic [7:0] modeState
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   a_tx_needs_reg: assert property (txEnabled |-> regEnable)
      else $error("transmitter on without regulator");
   a_drive_tx_low: assert property (!linOe_n |-> !$past(txData) && txEnabled)
      else $error("bus driven while transmit high or transmitter off");
   a_ready_quiet: assert property (modeState inside {8'h02, 8'h04} |-> !txEnabled && linOe_n && regEnable)
      else $error("ready mode outputs wrong");
   a_pd_off: assert property (modeState == 8'h10 |-> !regEnable && !txEnabled)
      else $error("power-down left something on");
   a_pd_from_op: assert property ($changed(modeState) && modeState == 8'h10 |-> $past(modeState) == 8'h08)
      else $error("power-down entered not from operation");
   a_op_entry: assert property ($changed(modeState) && modeState == 8'h08
                                |-> $past(modeState) inside {8'h02, 8'h10, 8'h20} && csArmed)
      else $error("operation entered from wrong mode or unarmed");
   a_hold_exit: assert property ($past(modeState) == 8'h04 && $changed(modeState)
                                 |-> modeState inside {8'h02, 8'h40, 8'h80})
      else $error("ready-hold left wrongly");
   a_overload_evt: assert property (regOverload || busOverload || thermalOverload |=> shutdownEvent)
      else $error("overload without shutdown event");
   a_rx_mirror: assert property (modeState == 8'h08 |-> rxData == $past(linIn))
      else $error("receive data not following bus");
   a_brownout_off: assert property (regEnable && regBelowThreshold |-> ##[1:4] !regEnable)
      else $error("regulator kept on below threshold");

   c_op: cover property (modeState == 8'h08);
   c_pd: cover property (modeState == 8'h10);
   c_fault: cover property (modeState == 8'h40);
   c_brown: cover property (modeState == 8'h80);
endmodule

bind ltmc_mode_control ltmc_mode_control_chk u_chk (
   .core_clk, .resetn, .txData, .linIn, .linOe_n, .rxData, .regEnable, .regBelowThreshold,
   .regOverload, .busOverload, .thermalOverload, .txEnabled, .shutdownEvent, .csArmed, .modeState
);
